// ### include/sas_cfg.svh
/*
  Constants of the serial sequencer for the 12-bit successive-approximation converter.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Overview of operation
// - frame is 16 bits MSB first: result in 15..4, four filler bits below
// - ground converts to 000h, one LSB under reference converts to FFFh
// - results clamp at FFFh above reference and 000h below ground
// - framing sampled on serial clock falls; host gives a fall while chip select high
// - chip-select-only: cs fall starts cycle, data changes on rising clock
// - frame-sync-only: MSB shown after sync rise, sync fall starts cycle
// - both framing signals: MSB shown after cs fall, later sync fall starts cycle
// - dual framing: cycle starts when sync falls while serial clock high
// - two-input variants: every chip select fall starts a cycle
// - DSP-framed single variant and two-input variants change data on falling clock
// - dual variant: chip select low for 4 to 7 clocks resets selector to 0
// - dual variant: low over 7 clocks toggles selector at chip select rise
// - sampling lasts 11 clocks from the fifth falling clock of the cycle
// - conversion starts after the 16th falling clock, done within 3.5 us
// - conversion runs 14 internal oscillator clocks of at least 4 MHz
// - framing high before conversion ends aborts it; next frame invalid
// - each frame carries the result of the previous cycle's sample
// - power down at end of conversion, wake on cs fall or sync rise
// - output released while cs high, driven after its fall, released after 16th clock
`ifndef SAS_CFG_SVH
`define SAS_CFG_SVH

`define SAS_FRAME_BITS      16
`define SAS_RESULT_BITS     12
`define SAS_FILL_BITS       4
`define SAS_AIN_BITS        14
`define SAS_FILL_VALUE      4'h0
`define SAS_CODE_ZERO       12'h000
`define SAS_CODE_FULL       12'hFFF
`define SAS_CODE_ONE        12'h001

`define SAS_EDGE_FIRST      5'h01
`define SAS_SAMPLE_FIRST    5'h05
`define SAS_SAMPLE_LAST     5'h10
`define SAS_CNT_MAX         5'h1F
`define SAS_CNT_ZERO        5'h00
`define SAS_SEL_RESET_MIN   5'h04
`define SAS_SEL_RESET_MAX   5'h07

`define SAS_SYS_CLK_HZ      40000000
`define SAS_OSC_MIN_HZ      4000000
`define SAS_OSC_DIV         (`SAS_SYS_CLK_HZ / `SAS_OSC_MIN_HZ)
`define SAS_CONV_TIME_NS    3500
`define SAS_CONV_OSC_CLKS   14
`define SAS_DIV_ZERO        4'h0
`define SAS_STEP_ZERO       4'h0
`define SAS_STEP_LAST       4'hD
`define SAS_STEP_MSB        4'hC

`endif

// ### include/sas_pkg.sv
/*
  Types and small helpers shared by the sequencer and the conversion core.
  Assumes sas_cfg.svh is on the include path.
*/
`include "sas_cfg.svh"

package sas_pkg;

  typedef enum logic [1:0] {
    SAS_SINGLE_SYNC,
    SAS_DUAL,
    SAS_PSEUDO_DIFF
  } sas_variant_e;

  typedef enum logic {
    SAS_CV_IDLE,
    SAS_CV_RUN
  } sas_conv_e;

  // state clocked on the falling serial clock edge
  typedef struct packed {
    logic                         cs_q;
    logic                         sync_q;
    logic                         in_frame;
    logic                         frame_by_sync;
    logic [4:0]                   cnt;
    logic [4:0]                   low_cnt;
    logic                         sel;
    logic                         sampling;
    logic [`SAS_AIN_BITS-1:0]     a0_s1;
    logic [`SAS_AIN_BITS-1:0]     a0_s2;
    logic [`SAS_AIN_BITS-1:0]     a1_s1;
    logic [`SAS_AIN_BITS-1:0]     a1_s2;
    logic [`SAS_AIN_BITS:0]       sample;
    logic                         start_tgl;
    logic                         end_tgl;
    logic                         wake_tgl;
    logic [2:0]                   done_s;
    logic [`SAS_RESULT_BITS-1:0]  word;
  } sas_link_s;

  // output shifter state
  typedef struct packed {
    logic [`SAS_FRAME_BITS-1:0]   shreg;
    logic                         oe_n;
  } sas_out_s;

  // conversion core state
  typedef struct packed {
    logic [2:0]                   start_s;
    logic [2:0]                   end_s;
    logic [2:0]                   wake_s;
    sas_conv_e                    st;
    logic [3:0]                   div;
    logic [3:0]                   step;
    logic [`SAS_AIN_BITS:0]       smp;
    logic [`SAS_RESULT_BITS-1:0]  trial;
    logic [`SAS_RESULT_BITS-1:0]  result;
    logic                         done_tgl;
    logic                         converting;
    logic                         power_down;
  } sas_core_s;

  function automatic logic sas_fell(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  function automatic logic sas_rose(input logic prev, input logic now);
    return ~prev & now;
  endfunction

  function automatic logic [4:0] sas_bump(input logic [4:0] c);
    return (c == `SAS_CNT_MAX) ? c : c + `SAS_EDGE_FIRST;
  endfunction

endpackage

// ### logic/sas_conv_core.sv
/*
  Conversion core on the system clock: internal oscillator by division,
  14-step successive approximation, abort and automatic power-down.
  Assumes start, end and wake arrive as toggles from the serial clock domain
  and that the sample word is stable whenever the start toggle changes.
*/
`timescale 1ns/10ps
`include "sas_cfg.svh"

module sas_conv_core
  import sas_pkg::*;
(
  // system
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  // from serial domain
  input  wire logic                         start_tgl,
  input  wire logic                         end_tgl,
  input  wire logic                         wake_tgl,
  input  wire logic [`SAS_AIN_BITS:0]       sample,
  // to serial domain and pins
  output logic      [`SAS_RESULT_BITS-1:0]  result,
  output logic                              done_tgl,
  output logic                              converting,
  output logic                              power_down
);

  sas_core_s c;
  sas_core_s next_c;

  logic                         start_ev;
  logic                         end_ev;
  logic                         wake_ev;
  logic                         osc_tick;
  logic [`SAS_RESULT_BITS-1:0]  test;

  assign start_ev   = c.start_s[1] ^ c.start_s[2];
  assign end_ev     = c.end_s[1] ^ c.end_s[2];
  assign wake_ev    = c.wake_s[1] ^ c.wake_s[2];
  assign osc_tick   = (c.div == 4'(`SAS_OSC_DIV - 1));
  assign test       = c.trial | (`SAS_CODE_ONE << (`SAS_STEP_MSB - c.step));
  assign result     = c.result;
  assign done_tgl   = c.done_tgl;
  assign converting = c.converting;
  assign power_down = c.power_down;

  always_comb begin
    next_c         = c;
    next_c.start_s = {c.start_s[1:0], start_tgl};
    next_c.end_s   = {c.end_s[1:0], end_tgl};
    next_c.wake_s  = {c.wake_s[1:0], wake_tgl};
    if (wake_ev) begin
      next_c.power_down = 1'b0;
    end
    unique case (c.st)
      SAS_CV_IDLE: begin
        if (start_ev) begin
          next_c.st         = SAS_CV_RUN;
          next_c.smp        = sample;
          next_c.div        = `SAS_DIV_ZERO;
          next_c.step       = `SAS_STEP_ZERO;
          next_c.trial      = `SAS_CODE_ZERO;
          next_c.converting = 1'b1;
          next_c.power_down = 1'b0;
        end
      end
      SAS_CV_RUN: begin
        next_c.div = osc_tick ? `SAS_DIV_ZERO : c.div + 4'h1;
        if (end_ev) begin
          // framing rose early: drop the conversion, mark next frame invalid
          next_c.st         = SAS_CV_IDLE;
          next_c.result     = `SAS_CODE_ZERO;
          next_c.done_tgl   = ~c.done_tgl;
          next_c.converting = 1'b0;
          next_c.power_down = 1'b1;
        end else if (osc_tick) begin
          next_c.step = c.step + 4'h1;
          if (c.step != `SAS_STEP_ZERO && c.step != `SAS_STEP_LAST) begin
            // negative samples never pass, over-range always passes
            if ($signed({3'b000, test}) <= $signed(c.smp)) begin
              next_c.trial = test;
            end
          end
          if (c.step == `SAS_STEP_LAST) begin
            next_c.st         = SAS_CV_IDLE;
            next_c.result     = c.trial;
            next_c.done_tgl   = ~c.done_tgl;
            next_c.converting = 1'b0;
            next_c.power_down = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

endmodule

// ### logic/sas_sequencer.sv
/*
  Serial sequencer of the 12-bit converter: framing decode, sampling window,
  16-bit output shifter, input selector and hand-off to the conversion core.
  Assumes the host owns sclk and keeps the framing signals in step with it;
  chip_select_n and frame_sync are therefore read in the sclk domain without
  synchronisers, while the analog input words pass two flops there.
*/
`timescale 1ns/10ps
`include "sas_cfg.svh"

module sas_sequencer
  import sas_pkg::*;
#(
  parameter sas_variant_e VARIANT     = SAS_SINGLE_SYNC,
  parameter bit           CS_FROM_DSP = 1'b0
)(
  // system
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  // serial link
  input  wire logic                      sclk,
  input  wire logic                      chip_select_n,
  input  wire logic                      frame_sync,
  output logic                           serial_data_out,
  output logic                           serial_data_out_oe_n,
  // analog inputs as signed LSB counts
  input  wire logic [`SAS_AIN_BITS-1:0]  analog_input_zero,
  input  wire logic [`SAS_AIN_BITS-1:0]  analog_input_one,
  // status
  output logic                           input_selector,
  output logic                           sampling,
  output logic                           converting,
  output logic                           power_down
);

  // variant decode, fixed at build time
  localparam bit SYNC_USED   = (VARIANT == SAS_SINGLE_SYNC);
  localparam bit SEL_USED    = (VARIANT == SAS_DUAL);
  localparam bit DIFF_USED   = (VARIANT == SAS_PSEUDO_DIFF);
  localparam bit OUT_ON_FALL = !SYNC_USED || CS_FROM_DSP;

  sas_link_s lk;
  sas_link_s next_lk;
  sas_out_s  ob;
  sas_out_s  next_ob;

  logic [`SAS_RESULT_BITS-1:0] core_result;
  logic                        core_done_tgl;

  logic                        cs_fall;
  logic                        cs_rise;
  logic                        sync_fall;
  logic                        sync_rise;
  logic                        start;
  logic                        frame_end;
  logic                        done_ev;
  logic [`SAS_AIN_BITS:0]      sel_word;

  // edges as seen on consecutive falling clock edges
  assign cs_fall = sas_fell(lk.cs_q, chip_select_n);
  assign cs_rise = sas_rose(lk.cs_q, chip_select_n);
  assign sync_fall = SYNC_USED && sas_fell(lk.sync_q, frame_sync);
  assign sync_rise = SYNC_USED && sas_rose(lk.sync_q, frame_sync);
  assign done_ev = lk.done_s[1] ^ lk.done_s[2];

  // cycle start for each framing mode
  always_comb begin
    start = 1'b0;
    if (!lk.in_frame) begin
      if (SYNC_USED) begin
        // sync high at cs fall: chip select alone frames the cycle
        if (cs_fall && frame_sync) begin
          start = 1'b1;
        end
        // sync falls with cs low; sampled low after high over the high clock phase
        if (sync_fall && !chip_select_n) begin
          start = 1'b1;
        end
      end else begin
        start = cs_fall;
      end
    end
  end

  // framing released: chip select, or frame sync when it opened the cycle
  assign frame_end = lk.in_frame && (chip_select_n || (lk.frame_by_sync && frame_sync));

  // value held on the sampling capacitor
  always_comb begin
    if (DIFF_USED) begin
      sel_word = {lk.a0_s2[`SAS_AIN_BITS-1], lk.a0_s2}
               - {lk.a1_s2[`SAS_AIN_BITS-1], lk.a1_s2};
    end else if (SEL_USED && lk.sel) begin
      sel_word = {lk.a1_s2[`SAS_AIN_BITS-1], lk.a1_s2};
    end else begin
      sel_word = {lk.a0_s2[`SAS_AIN_BITS-1], lk.a0_s2};
    end
  end

  // falling-edge state: framing, counts, sampling, selector, crossings
  always_comb begin
    next_lk        = lk;
    next_lk.cs_q   = chip_select_n;
    next_lk.sync_q = frame_sync;
    next_lk.a0_s1  = analog_input_zero;
    next_lk.a0_s2  = lk.a0_s1;
    next_lk.a1_s1  = analog_input_one;
    next_lk.a1_s2  = lk.a1_s1;
    next_lk.done_s = {lk.done_s[1:0], core_done_tgl};

    // result of the finished conversion waits for the next frame
    if (done_ev) begin
      next_lk.word = core_result;
    end

    // wake the core at cs fall or sync rise
    if (cs_fall || sync_rise) begin
      next_lk.wake_tgl = ~lk.wake_tgl;
    end

    if (start) begin
      next_lk.in_frame = 1'b1;
      next_lk.frame_by_sync = SYNC_USED && sync_fall && !(cs_fall && frame_sync);
      next_lk.cnt      = `SAS_EDGE_FIRST;
    end else if (frame_end) begin
      // an end while the core is converting is turned into an abort there; the core ignores an end before its start
      next_lk.in_frame = 1'b0;
      next_lk.frame_by_sync = 1'b0;
      next_lk.cnt      = `SAS_CNT_ZERO;
      next_lk.sampling = 1'b0;
      next_lk.end_tgl  = ~lk.end_tgl;
    end else if (lk.in_frame) begin
      next_lk.cnt = sas_bump(lk.cnt);
      if (next_lk.cnt == `SAS_SAMPLE_FIRST) begin
        next_lk.sampling = 1'b1;
      end
      if (next_lk.cnt == `SAS_SAMPLE_LAST) begin
        // hold the sample and start the core after the 16th fall
        next_lk.sampling  = 1'b0;
        next_lk.sample    = sel_word;
        next_lk.start_tgl = ~lk.start_tgl;
      end
    end

    // selector: count low clocks, act at the chip select rise
    if (SEL_USED) begin
      if (!chip_select_n) begin
        next_lk.low_cnt = sas_bump(lk.low_cnt);
      end else begin
        next_lk.low_cnt = `SAS_CNT_ZERO;
      end
      if (cs_rise) begin
        if (lk.low_cnt > `SAS_SEL_RESET_MAX) begin
          next_lk.sel = ~lk.sel;
        end else if (lk.low_cnt >= `SAS_SEL_RESET_MIN) begin
          next_lk.sel = 1'b0;
        end
      end
    end
  end

  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      lk      <= '0;
      lk.cs_q <= 1'b1;
      lk.sync_q <= 1'b1;
    end else begin
      lk <= next_lk;
    end
  end

  // output shifter: loads while idle, shifts once per clock in the frame until the 16th clock
  always_comb begin
    next_ob = ob;
    if (!lk.in_frame) begin
      next_ob.shreg = {lk.word, `SAS_FILL_VALUE};
      next_ob.oe_n  = chip_select_n;
    end else if (lk.cnt >= `SAS_SAMPLE_LAST || chip_select_n) begin
      next_ob.oe_n = 1'b1;
    end else begin
      next_ob.shreg = {ob.shreg[`SAS_FRAME_BITS-2:0], 1'b0};
      next_ob.oe_n  = 1'b0;
    end
  end

  // one shifter edge per variant; the other never exists
  generate
    if (OUT_ON_FALL) begin : g_out_fall
      always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
          ob      <= '0;
          ob.oe_n <= 1'b1;
        end else begin
          ob <= next_ob;
        end
      end
    end else begin : g_out_rise
      always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
          ob      <= '0;
          ob.oe_n <= 1'b1;
        end else begin
          ob <= next_ob;
        end
      end
    end
  endgenerate

  assign serial_data_out      = ob.shreg[`SAS_FRAME_BITS-1];
  assign serial_data_out_oe_n = ob.oe_n;
  assign input_selector       = lk.sel;
  assign sampling             = lk.sampling;

  sas_conv_core u_core (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .start_tgl  (lk.start_tgl),
    .end_tgl    (lk.end_tgl),
    .wake_tgl   (lk.wake_tgl),
    .sample     (lk.sample),
    .result     (core_result),
    .done_tgl   (core_done_tgl),
    .converting (converting),
    .power_down (power_down)
  );

endmodule

// ### dv/sas_seq_assertions.sv
/*
  Concurrent checks on the serial sequencer ports, bound into sas_sequencer.
  Assumes sclk stands still between frames and is given a few falls with
  chip select high after each frame.
*/
`timescale 1ns/10ps
`include "sas_cfg.svh"

module sas_seq_assertions
  import sas_pkg::*;
#(
  parameter sas_variant_e VARIANT = SAS_SINGLE_SYNC
)(
  // system
  input wire logic                      sys_clk,
  input wire logic                      rst_n,
  // serial link
  input wire logic                      sclk,
  input wire logic                      chip_select_n,
  input wire logic                      frame_sync,
  input wire logic                      serial_data_out,
  input wire logic                      serial_data_out_oe_n,
  // analog inputs
  input wire logic [`SAS_AIN_BITS-1:0]  analog_input_zero,
  input wire logic [`SAS_AIN_BITS-1:0]  analog_input_one,
  // status
  input wire logic                      input_selector,
  input wire logic                      sampling,
  input wire logic                      converting,
  input wire logic                      power_down
);
  localparam int CONV_CYC = `SAS_CONV_OSC_CLKS * `SAS_OSC_DIV;
  localparam bit DUAL     = (VARIANT == SAS_DUAL);
  logic [7:0] conv_cnt;
  logic [4:0] low_cnt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) conv_cnt <= 8'h00;
    else conv_cnt <= converting ? conv_cnt + 8'h01 : 8'h00;
  end

  // saturates so a long conversion frame never wraps into the 4..7 band
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) low_cnt <= 5'h00;
    else if (chip_select_n) low_cnt <= 5'h00;
    else if (low_cnt != 5'h1F) low_cnt <= low_cnt + 5'h01;
  end

  a_conv_len_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    converting |-> conv_cnt < CONV_CYC) else $error("conversion too long");
  a_conv_after_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(sampling) |-> ##[1:12] converting) else $error("conversion did not start");
  a_pd_at_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(converting) |-> ##[0:2] power_down) else $error("no power down");
  a_sample_len: assert property (@(negedge sclk) disable iff (!rst_n)
    $rose(sampling) |-> sampling[*8] ##1 sampling[*3] ##1 !sampling)
    else $error("sampling window length wrong");
  a_sample_start: assert property (@(negedge sclk) disable iff (!rst_n)
    $rose(sampling) |-> !$past(chip_select_n, 5) && $past(chip_select_n, 6))
    else $error("sampling began at wrong clock");
  a_oe_released: assert property (@(negedge sclk) disable iff (!rst_n)
    chip_select_n && $past(chip_select_n) |-> serial_data_out_oe_n)
    else $error("output driven with chip select high");
  a_sel_toggle: assert property (@(negedge sclk) disable iff (!rst_n)
    DUAL && chip_select_n && low_cnt > 5'h07 |=> input_selector != $past(input_selector))
    else $error("selector did not toggle");
  a_sel_reset: assert property (@(negedge sclk) disable iff (!rst_n)
    DUAL && chip_select_n && low_cnt >= 5'h04 && low_cnt <= 5'h07 |=> !input_selector)
    else $error("selector not reset");

  c_sample: cover property (@(negedge sclk) $rose(sampling));
  c_conv_end: cover property (@(posedge sys_clk) $fell(converting));
  c_short_cycle: cover property (@(negedge sclk) chip_select_n && low_cnt == 5'h04);
endmodule

bind sas_sequencer sas_seq_assertions #(.VARIANT(VARIANT)) chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .chip_select_n(chip_select_n),
  .frame_sync(frame_sync), .serial_data_out(serial_data_out),
  .serial_data_out_oe_n(serial_data_out_oe_n), .analog_input_zero(analog_input_zero),
  .analog_input_one(analog_input_one), .input_selector(input_selector),
  .sampling(sampling), .converting(converting), .power_down(power_down));

// ### dv/sas_host_model.sv
/*
  Serial host: drives sclk (15 ns) and chip select, reads the output line.
  Assumes a falling-edge output variant; sclk stands still outside calls.
*/
`timescale 1ns/10ps

module sas_host_model (
  // serial link
  output logic      sclk,
  output logic      chip_select_n,
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe_n
);
  logic line_last;

  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    line_last = 1'b0;
  end

  // released line has no pull: show the inverse of its last level
  task automatic tick(output logic b, output logic z);
    sclk = 1'b1;
    #7.5;
    sclk = 1'b0;
    #3;
    z = serial_data_out_oe_n;
    b = z ? ~line_last : serial_data_out;
    line_last = b;
    #4.5;
  endtask

  task automatic idle(input int n);
    logic b, z;
    repeat (n) tick(b, z);
  endtask

  task automatic frame(input int n, input int hold, output logic [15:0] w,
                       output logic oe_bad);
    logic b, z;
    w = 16'h0000;
    oe_bad = 1'b0;
    chip_select_n = 1'b0;
    #60;
    for (int k = 0; k < n; k++) begin
      tick(b, z);
      if (k < 16) begin
        w = {w[14:0], b};
        oe_bad |= z;
      end
    end
    // low through conversion plus one clock; a short hold aborts
    if (n == 16) begin
      #(hold);
      tick(b, z);
      oe_bad |= ~z;
    end
    chip_select_n = 1'b1;
    #60;
  endtask
endmodule

// ### dv/sar_adc_serial_sequencer_tb.sv
/*
  Self-checking bench of the dual-input sequencer with a serial host model.
  Assumes the checker file is compiled with it and binds itself.
*/
`timescale 1ns/10ps
`include "sas_cfg.svh"

`define CHK(nm, e, g) \
  samples_checked++; \
  if ((g) !== (e)) begin \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); \
    errors++; \
  end

module sar_adc_serial_sequencer_tb
  import sas_pkg::*;
;
  logic                     sys_clk, rst_n, sclk, chip_select_n, frame_sync;
  logic                     sdata, sdata_oe_n, input_selector, sampling;
  logic                     converting, power_down;
  logic [`SAS_AIN_BITS-1:0] in_zero, in_one;
  logic [15:0]              rnd;
  int                       errors, samples_checked;

  sas_sequencer #(.VARIANT(SAS_DUAL), .CS_FROM_DSP(1'b0)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .chip_select_n(chip_select_n),
    .frame_sync(frame_sync), .serial_data_out(sdata), .serial_data_out_oe_n(sdata_oe_n),
    .analog_input_zero(in_zero), .analog_input_one(in_one),
    .input_selector(input_selector), .sampling(sampling),
    .converting(converting), .power_down(power_down));

  sas_host_model host_u (.sclk(sclk), .chip_select_n(chip_select_n),
    .serial_data_out(sdata), .serial_data_out_oe_n(sdata_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // signed input in LSBs, clamped to the 12-bit code range
  function automatic logic [11:0] exp_code(input logic [13:0] a);
    if (a[13]) return 12'h000;
    if (a[12]) return 12'hFFF;
    return a[11:0];
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic run(input int n, input int hold, input logic [11:0] e, input bit chk);
    logic [15:0] w;
    logic        z;
    host_u.frame(n, hold, w, z);
    host_u.idle(4);
    if (chk) begin
      `CHK("frame word", {e, `SAS_FILL_VALUE}, w)
      `CHK("output enable", 1'b0, z)
    end
    if (n == 16 && hold > 1000) begin
      `CHK("power down", 1'b1, power_down)
    end
    $display("frame of %0d clocks done", n);
  endtask

  initial begin
    #500000;
    errors++;
    wrap_up();
  end

  initial begin
    logic [13:0] v0, v1;
    logic [11:0] prev, cur;
    logic        sel;
    logic [13:0] corner [4];
    corner = '{14'h0000, 14'h0FFF, 14'h1000, 14'h3FFF};
    rst_n = 1'b0;
    frame_sync = 1'b1;
    in_zero = '0;
    in_one = '0;
    errors = 0;
    samples_checked = 0;
    rnd = 16'h5F8E; // seed 24462
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk) rst_n <= 1'b1;
    host_u.idle(2);
    sel = 1'b0;
    prev = 12'h000;
    // first frame is the dummy cycle before any selector reset
    for (int i = 0; i < 15; i++) begin
      if (i == 13) begin
        run(4, 0, 12'h000, 1'b0);
        `CHK("selector reset", 1'b0, input_selector)
        sel = 1'b0;
      end
      rnd = lfsr(rnd);
      v0 = rnd[13:0];
      rnd = lfsr(rnd);
      v1 = rnd[13:0];
      if (i < 4) begin
        v0 = corner[i];
        v1 = corner[i];
      end
      @(negedge sys_clk);
      in_zero <= v0;
      in_one <= v1;
      cur = exp_code(sel ? v1 : v0);
      if (i == 12) begin
        run(16, 600, prev, 1'b1);
        cur = 12'h000;
      end else begin
        run(16, 4200, prev, 1'b1);
      end
      `CHK("selector", ~sel, input_selector)
      sel = ~sel;
      prev = cur;
    end
    wrap_up();
  end
endmodule
